/* hw/sifs_pkg.sv */
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types of the servo input function select block.
package sifs_pkg;

   // APB geometry.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_ASSIGN  = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_ACTIVE  = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h00c;

   // Allocation setting layout: four decimal digits, one nibble each.
   localparam int SET_W      = 16;
   localparam int DIGIT_W    = 4;
   localparam int FUNC_COUNT = 3;
   localparam int TERM_COUNT = 8;
   localparam int TERM_SEL_W = 3;

   // Reset value of the setting: every function forced inactive.
   localparam logic [SET_W-1:0] ASSIGN_RESET = 16'h0888;

   // Last terminal number and the digit codes beyond it.
   localparam logic [DIGIT_W-1:0] CODE_LAST_TERM = 4'h7;
   localparam logic [DIGIT_W-1:0] CODE_FORCE_OFF = 4'h8;
   localparam logic [DIGIT_W-1:0] CODE_FORCE_ON  = 4'h9;

   // Function indices, equal to the digit position of each selection.
   localparam int FUNC_CLAMP   = 0;
   localparam int FUNC_INHIBIT = 1;
   localparam int FUNC_GAIN    = 2;

   // Control register bits.
   localparam int CTL_APPLY = 0;
   localparam int CTL_AUTO  = 1;

   // Status register fields.
   localparam int ST_TERM_LSB    = 0;
   localparam int ST_FUNC_LSB    = 8;
   localparam int ST_PENDING     = 11;
   localparam int ST_INVALID_LSB = 12;

   // Function outputs towards the motion control logic.
   typedef struct packed {
      logic gainSwitch;
      logic pulseInhibit;
      logic zeroClamp;
   } sifs_func_type;

   // One APB request as seen by the slave.
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } sifs_apb_req_type;

endpackage

/* hw/sifs_select.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// One function source selector: a terminal, forced off or forced on.
module sifs_select (
   input  wire logic [sifs_pkg::TERM_COUNT-1:0] terminalLevel,
   input  wire logic [sifs_pkg::DIGIT_W-1:0]    selectDigit,
   output logic                                 funcLevel,
   output logic                                 digitInvalid
);
   import sifs_pkg::*;

   // Decode the digit; codes above nine are treated as forced off and flagged.
   always_comb begin
      funcLevel    = 1'b0;
      digitInvalid = 1'b0;
      if (selectDigit <= CODE_LAST_TERM) begin
         funcLevel = terminalLevel[selectDigit[TERM_SEL_W-1:0]];
      end else if (selectDigit == CODE_FORCE_OFF) begin
         funcLevel = 1'b0;
      end else if (selectDigit == CODE_FORCE_ON) begin
         funcLevel = 1'b1;
      end else begin
         digitInvalid = 1'b1;
      end
   end

endmodule

/* hw/sifs_top.sv */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Input function allocation with an APB register file.
module sifs_top (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [sifs_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [sifs_pkg::DATA_W-1:0]   pwdata,
   output logic      [sifs_pkg::DATA_W-1:0]   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [sifs_pkg::TERM_COUNT-1:0] inputTerminal,
   output sifs_pkg::sifs_func_type            funcOut
);
   import sifs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Extract one selection digit from a setting word.
   function automatic logic [DIGIT_W-1:0] digitOf(
      input logic [SET_W-1:0] setting,
      input int               index
   );
      digitOf = setting[index*DIGIT_W +: DIGIT_W];
   endfunction

   // Tell whether an address names a mapped register.
   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      isMapped = (addr == OFS_ASSIGN) || (addr == OFS_ACTIVE) ||
                 (addr == OFS_CONTROL) || (addr == OFS_STATUS);
   endfunction

   // Tell whether an address names a register that accepts writes.
   function automatic logic isWritable(input logic [ADDR_W-1:0] addr);
      isWritable = (addr == OFS_ASSIGN) || (addr == OFS_CONTROL);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   sifs_apb_req_type            apbReq;
   logic                        setupPhase;
   logic                        accessDone;
   logic                        writeAccept;
   logic [SET_W-1:0]            assign_reg;
   logic [SET_W-1:0]            assign_next;
   logic [SET_W-1:0]            active_reg;
   logic [SET_W-1:0]            active_next;
   logic                        autoApply_reg;
   logic                        applyPulse;
   logic [TERM_COUNT-1:0]       terminal_reg;
   logic [FUNC_COUNT-1:0]       funcLevel;
   logic [FUNC_COUNT-1:0]       funcInvalid;
   logic [FUNC_COUNT-1:0]       funcOut_reg;
   logic [FUNC_COUNT-1:0]       invalid_reg;
   logic [DATA_W-1:0]           readValue;
   logic [DATA_W-1:0]           prdata_reg;
   logic                        pslverr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // APB phase decode.

   // Gather the request into one carrier and decode its phases.
   assign apbReq      = '{psel, penable, pwrite, paddr, pwdata};
   assign setupPhase  = apbReq.psel && !apbReq.penable;
   assign accessDone  = apbReq.psel && apbReq.penable;
   assign writeAccept = accessDone && apbReq.pwrite && isWritable(apbReq.paddr);
   assign pready      = accessDone; // Every access finishes in its first access cycle.
   assign pslverr     = pslverr_reg && accessDone;
   assign prdata      = prdata_reg;

   // Apply is a write of one to the apply bit of the control register.
   assign applyPulse = writeAccept && (apbReq.paddr == OFS_CONTROL) && apbReq.pwdata[CTL_APPLY];

   ////////////////////////////////////////////////////////////////////////////
   // Setting registers.

   // Next value of the pending setting; the reserved top digit is stored as written.
   always_comb begin
      assign_next = assign_reg;
      if (writeAccept && (apbReq.paddr == OFS_ASSIGN)) begin
         assign_next = apbReq.pwdata[SET_W-1:0];
      end
   end

   // Pending setting register.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         assign_reg <= ASSIGN_RESET;
      end else begin
         assign_reg <= assign_next;
      end
   end

   // The active setting follows the pending one on apply, or at once in auto mode.
   always_comb begin
      active_next = active_reg;
      if (applyPulse) begin
         active_next = assign_next;
      end else if (autoApply_reg) begin
         active_next = assign_next;
      end
   end

   // Active setting register, the one the selectors use.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         active_reg <= ASSIGN_RESET;
      end else begin
         active_reg <= active_next;
      end
   end

   // Auto apply mode bit of the control register.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         autoApply_reg <= 1'b0;
      end else if (writeAccept && (apbReq.paddr == OFS_CONTROL)) begin
         autoApply_reg <= apbReq.pwdata[CTL_AUTO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Terminal sampling and function selection.

   // Sample the terminals once so every selector sees the same level.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         terminal_reg <= '0;
      end else begin
         terminal_reg <= inputTerminal;
      end
   end

   // One selector per function; digit index equals function index.
   // The top digit is never decoded, so a stray value there changes no function output.
   generate
      for (genvar f = 0; f < FUNC_COUNT; f++) begin : g_func
         sifs_select u_select (
            .terminalLevel (terminal_reg),
            .selectDigit   (digitOf(active_reg, f)),
            .funcLevel     (funcLevel[f]),
            .digitInvalid  (funcInvalid[f])
         );
      end
   endgenerate

   // Register the selected levels every cycle towards the motion logic.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         funcOut_reg <= '0;
         invalid_reg <= '0;
      end else begin
         funcOut_reg <= funcLevel;
         invalid_reg <= funcInvalid;
      end
   end

   // Map the function vector onto the output carrier.
   assign funcOut.zeroClamp    = funcOut_reg[FUNC_CLAMP];
   assign funcOut.pulseInhibit = funcOut_reg[FUNC_INHIBIT];
   assign funcOut.gainSwitch   = funcOut_reg[FUNC_GAIN];

   ////////////////////////////////////////////////////////////////////////////
   // Register read path.

   // Select the read value; unmapped addresses read zero.
   always_comb begin
      readValue = '0;
      case (apbReq.paddr)
         OFS_ASSIGN: begin
            readValue[SET_W-1:0] = assign_reg;
         end
         OFS_ACTIVE: begin
            readValue[SET_W-1:0] = active_reg;
         end
         OFS_CONTROL: begin
            readValue[CTL_AUTO] = autoApply_reg;
         end
         OFS_STATUS: begin
            readValue[ST_TERM_LSB +: TERM_COUNT]    = terminal_reg;
            readValue[ST_FUNC_LSB +: FUNC_COUNT]    = funcOut_reg;
            readValue[ST_PENDING]                   = (assign_reg != active_reg);
            readValue[ST_INVALID_LSB +: FUNC_COUNT] = invalid_reg;
         end
         default: begin
            readValue = '0;
         end
      endcase
   end

   // Capture read data and error in the setup cycle so both come from flops.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (setupPhase) begin
         prdata_reg  <= apbReq.pwrite ? '0 : readValue;
         pslverr_reg <= !isMapped(apbReq.paddr) ||
                        (apbReq.pwrite && !isWritable(apbReq.paddr));
      end
   end

endmodule

/* test/sifs_terminal_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// Host side terminals: levels change just after a clock edge and then hold.
module sifs_terminal_model (
   input  wire logic                            sys_clk,
   output logic      [sifs_pkg::TERM_COUNT-1:0] inputTerminal
);
   initial inputTerminal = '0;
   // Puts a new set of levels on the terminals at the next rising edge.
   task automatic drive(input logic [7:0] lvl);
      @(posedge sys_clk);
      inputTerminal <= lvl;
   endtask
endmodule

/* test/sifs_top_properties.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// Checks each function output against a shadow of the applied setting.
module sifs_top_properties (
   input wire logic                            sys_clk,
   input wire logic                            rst,
   input wire logic                            psel,
   input wire logic                            penable,
   input wire logic                            pwrite,
   input wire logic [sifs_pkg::ADDR_W-1:0]     paddr,
   input wire logic [sifs_pkg::DATA_W-1:0]     pwdata,
   input wire logic [sifs_pkg::TERM_COUNT-1:0] inputTerminal,
   input wire sifs_pkg::sifs_func_type         funcOut
);
   import sifs_pkg::*;
   logic [SET_W-1:0] asgReg;
   logic [SET_W-1:0] actReg;
   logic [SET_W-1:0] actDly;
   logic             autoReg;
   logic [7:0]       termA;
   logic [7:0]       termB;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Level that one selection digit asks for.
   function automatic logic pick(logic [3:0] d, logic [7:0] t);
      return (d <= CODE_LAST_TERM) ? t[d[2:0]] : (d == CODE_FORCE_ON);
   endfunction
   ////////////////////////////////////////
   // Shadow of the pending and applied settings, kept from APB writes.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         asgReg <= ASSIGN_RESET;
         actReg <= ASSIGN_RESET;
         autoReg <= 1'b0;
      end else if (psel && penable && pwrite) begin
         if (paddr == OFS_ASSIGN) begin
            asgReg <= pwdata[SET_W-1:0];
            if (autoReg) actReg <= pwdata[SET_W-1:0];
         end
         if (paddr == OFS_CONTROL) begin
            autoReg <= pwdata[CTL_AUTO];
            if (pwdata[CTL_APPLY]) actReg <= asgReg;
         end
      end
   end
   // Delays that line causes up with the two-stage output path.
   always_ff @(posedge sys_clk) begin
      termA <= inputTerminal;
      termB <= termA;
      actDly <= actReg;
   end
   ////////////////////////////////////////
   property p_clamp_term;
      actDly[3:0] <= CODE_LAST_TERM |-> funcOut.zeroClamp == termB[actDly[2:0]];
   endproperty
   a_clamp_term: assert property (p_clamp_term)
      else $error("zero clamp does not follow its terminal");
   property p_clamp_off;
      actDly[3:0] == CODE_FORCE_OFF |-> !funcOut.zeroClamp;
   endproperty
   a_clamp_off: assert property (p_clamp_off)
      else $error("zero clamp active while forced off");
   property p_clamp_on;
      actDly[3:0] == CODE_FORCE_ON |-> funcOut.zeroClamp;
   endproperty
   a_clamp_on: assert property (p_clamp_on)
      else $error("zero clamp inactive while forced on");
   property p_inhibit;
      funcOut.pulseInhibit == pick(actDly[7:4], termB);
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("pulse inhibit source wrong");
   property p_gain;
      funcOut.gainSwitch == pick(actDly[11:8], termB);
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain switch source wrong");
   property p_static;
      $stable(actDly) && $stable(termB) |-> $stable(funcOut);
   endproperty
   a_static: assert property (p_static)
      else $error("function output moved with steady inputs");
   c_term: cover property (actDly[3:0] <= CODE_LAST_TERM && $rose(funcOut.zeroClamp));
   c_force: cover property (actDly[11:8] == CODE_FORCE_ON && funcOut.gainSwitch);
   c_apply: cover property (psel && penable && pwrite && paddr == OFS_CONTROL && pwdata[0]);
endmodule

/* test/sifs_top_tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// Drives the selector over APB and the terminals, and checks the outputs.
module sifs_top_tb;
   import sifs_pkg::*;
   logic                  sys_clk = 1'b0;
   logic                  rst     = 1'b1;
   logic                  psel    = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite  = 1'b0;
   logic [ADDR_W-1:0]     paddr   = '0;
   logic [DATA_W-1:0]     pwdata  = '0;
   logic [DATA_W-1:0]     prdata;
   logic [DATA_W-1:0]     rd;
   logic                  pready;
   logic                  pslverr;
   logic                  err;
   logic [TERM_COUNT-1:0] inputTerminal;
   sifs_func_type         funcOut;
   logic [31:0]           seed = 32'h13ff;
   logic [SET_W-1:0]      cur;
   logic [SET_W-1:0]      nxt;
   int                    num_errors = 0;
   int                    tests_run = 0;
   // Clock of 10 ns.
   always #5 sys_clk = ~sys_clk;
   sifs_top i_sifs_top (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .inputTerminal, .funcOut);
   sifs_terminal_model i_sifs_terminal_model (.sys_clk, .inputTerminal);
   ////////////////////////////////////////
   // Xorshift source of random values.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected function levels for a setting and a terminal set.
   function automatic logic [2:0] expf(logic [SET_W-1:0] s, logic [7:0] t);
      logic [3:0] d;
      for (int k = 0; k < FUNC_COUNT; k++) begin
         d = s[DIGIT_W*k +: DIGIT_W];
         expf[k] = (d <= CODE_LAST_TERM) ? t[d[2:0]] : (d == CODE_FORCE_ON);
      end
   endfunction
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, 32'(pready));
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Corner and random terminal sets, each checked once the path settles.
   task automatic terms(input logic [SET_W-1:0] s);
      logic [7:0] t;
      for (int j = 0; j < 3; j++) begin
         t = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'(rnd());
         i_sifs_terminal_model.drive(t);
         repeat (3) @(posedge sys_clk);
         chk("funcOut", 32'(expf(s, t)), 32'(funcOut));
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, OFS_ASSIGN, '0);
      chk("assign", 32'(ASSIGN_RESET), rd);
      apb(1'b0, OFS_ACTIVE, '0);
      chk("active", 32'(ASSIGN_RESET), rd);
      apb(1'b0, 12'h010, '0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      apb(1'b1, OFS_STATUS, 32'hffff);
      chk("ro write", 32'h1, 32'(err));
      $display("Register map test done");
      apb(1'b1, OFS_CONTROL, 32'h2);
      for (int k = 0; k < 11; k++) begin
         cur = {4'h0, 4'((k + 6) % 11), 4'((k + 3) % 11), 4'(k)};
         apb(1'b1, OFS_ASSIGN, 32'(cur));
         terms(cur);
      end
      $display("Digit code sweep done");
      apb(1'b1, OFS_CONTROL, 32'h0);
      nxt = {4'h0, 4'(rnd() % 10), 4'(rnd() % 10), 4'(rnd() % 10)};
      apb(1'b1, OFS_ASSIGN, 32'(nxt));
      apb(1'b0, OFS_ACTIVE, '0);
      chk("active held", 32'(cur), rd);
      terms(cur);
      apb(1'b1, OFS_CONTROL, 32'h1);
      apb(1'b0, OFS_ACTIVE, '0);
      chk("active applied", 32'(nxt), rd);
      terms(nxt);
      $display("Apply step test done");
      complete_run();
   end
   // Watchdog far beyond the expected run length.
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end
endmodule
bind sifs_top sifs_top_properties i_sifs_top_properties (.sys_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .inputTerminal, .funcOut);
